/* File: rtl/dft_pkg.sv */
// constants and types shared by the deferred fault token unit
// assumes one core clock and one instruction slot per cycle
package dft_pkg;
	localparam int GR_NUM = 128;
	localparam int REG_W = 7;
	localparam int ADDR_W = 64;
	localparam int DATA_W = 64;
	localparam int FP_W = 82;
	localparam int SIZE_W = 4;
	localparam int TGT_W = 64;
	localparam int UCR_W = 64;
	localparam int SEL_HI = 8;
	localparam int SEL_LO = 3;
	localparam int ADVANCED_LOAD_ADDRESS_TABLE_NUM = 16;
	localparam logic [FP_W-1:0] FP_TOKEN_VAL = 82'h1fffe0000000000000000;
	localparam logic [SIZE_W-1:0] SPILL_SIZE = 4'h8;

	typedef enum logic [3:0] {
		OP_ALU, OP_LD, OP_LD_S, OP_LD_A, OP_SPECULATIVE_ADVANCED_LOAD, OP_ST, OP_SPILL,
		OP_FILL, OP_CHK_S, OP_CHK_A, OP_TNAT, OP_FCLASS, OP_FSPILL,
		OP_FFILL
	} dft_op_t;
endpackage

/* File: rtl/dft_advanced_load_address_table_if.sv */
// signals between the token unit and its advanced-load table
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface dft_advanced_load_address_table_if;
	import dft_pkg::*;
	logic alloc;
	logic [REG_W-1:0] alloc_reg;
	logic [ADDR_W-1:0] alloc_addr;
	logic [SIZE_W-1:0] alloc_size;
	logic alloc_fp;
	logic store;
	logic [ADDR_W-1:0] st_addr;
	logic [SIZE_W-1:0] st_size;
	logic [REG_W-1:0] chk_reg;
	logic chk_fp;
	logic chk_hit;
	logic drop;
	modport core (output alloc, alloc_reg, alloc_addr, alloc_size,
		alloc_fp, store, st_addr, st_size, chk_reg, chk_fp, drop,
		input chk_hit);
	modport tbl (input alloc, alloc_reg, alloc_addr, alloc_size,
		alloc_fp, store, st_addr, st_size, chk_reg, chk_fp, drop,
		output chk_hit);
endinterface

/* File: rtl/dft_advanced_load_address_table.sv */
// advanced-load table: direct mapped on physical register number
// assumes at most one allocation and one store per cycle
`timescale 1ns/1ps
module dft_advanced_load_address_table
	import dft_pkg::*;
#(
	parameter int NUM = ADVANCED_LOAD_ADDRESS_TABLE_NUM
) (
	input wire logic clk,
	input wire logic srst,
	dft_advanced_load_address_table_if.tbl t
);
	localparam int IW = $clog2(NUM);

	initial begin
		if (NUM < 2 || (NUM & (NUM - 1)) != 0 || NUM > GR_NUM)
			$error("dft_advanced_load_address_table: NUM must be a power of two up to GR_NUM");
	end

	logic [NUM-1:0] vld_ff, nxt_vld;
	logic [REG_W-1:0] reg_ff [NUM];
	logic [REG_W-1:0] nxt_reg [NUM];
	logic [ADDR_W-1:0] addr_ff [NUM];
	logic [ADDR_W-1:0] nxt_addr [NUM];
	logic [SIZE_W-1:0] size_ff [NUM];
	logic [SIZE_W-1:0] nxt_size [NUM];
	logic [NUM-1:0] fp_ff, nxt_fp;
	logic [IW-1:0] ai, ci;

	assign ai = t.alloc_reg[IW-1:0];
	assign ci = t.chk_reg[IW-1:0];
	assign t.chk_hit = vld_ff[ci] && reg_ff[ci] == t.chk_reg &&
		fp_ff[ci] == t.chk_fp;

	always_comb begin
		nxt_vld = vld_ff;
		nxt_reg = reg_ff;
		nxt_addr = addr_ff;
		nxt_size = size_ff;
		nxt_fp = fp_ff;
		for (int i = 0; i < NUM; i++) begin
			if (t.store && t.st_addr < addr_ff[i] + ADDR_W'(size_ff[i]) &&
				addr_ff[i] < t.st_addr + ADDR_W'(t.st_size))
				nxt_vld[i] = 1'b0;
		end
		if (t.drop)
			nxt_vld[ai] = 1'b0;
		if (t.alloc) begin
			nxt_vld[ai] = 1'b1;
			nxt_reg[ai] = t.alloc_reg;
			nxt_addr[ai] = t.alloc_addr;
			nxt_size[ai] = t.alloc_size;
			nxt_fp[ai] = t.alloc_fp;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			vld_ff <= '0;
		end else begin
			vld_ff <= nxt_vld;
		end
		reg_ff <= nxt_reg;
		addr_ff <= nxt_addr;
		size_ff <= nxt_size;
		fp_ff <= nxt_fp;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	property p_alloc_hit;
		t.alloc ##1 (t.chk_reg == $past(t.alloc_reg) &&
			t.chk_fp == $past(t.alloc_fp)) |-> t.chk_hit;
	endproperty
	a_alloc_hit: assert property (p_alloc_hit)
		else $error("check missed entry just allocated");
endmodule

/* File: rtl/dft_core.sv */
// deferred fault token unit: per-register tokens, checks, spill and fill
// assumes one decoded instruction per cycle, results one cycle later
//
// Behaviour
// - every general register carries one extra token bit
// - token bit at one marks register as deferred fault, not data
// - floating-point deferral is a special token value in the register
// - deferred fault on control speculative load sets destination token
// - speculative op reading tokened source sets all its destination tokens
// - non-speculative read of tokened register raises consumption fault
// - speculation check on tokened register branches to recovery target
// - token-test and fp class report token bit or token value
// - spill store writes eight bytes and copies token to collection
// - address bits 8 to 3 select the collection bit
// - fill load reads eight bytes, token from selected collection bit
// - fp spill and fill never fault on the fp token value
// - speculative advanced load with token allocates no table entry
// - full table may replace an existing entry
// - tokens live per register so loads never disturb each other
// - table indexed by physical register, holding address type size
// - advanced check continues on match, else branches to recovery
// - stores remove table entries with overlapping address range
`timescale 1ns/1ps
module dft_core
	import dft_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic ins_valid,
	input wire dft_op_t ins_op,
	input wire logic ins_spec,
	input wire logic ins_fp,
	input wire logic ins_src1_use,
	input wire logic ins_src2_use,
	input wire logic [REG_W-1:0] ins_src1,
	input wire logic [REG_W-1:0] ins_src2,
	input wire logic ins_dst_use,
	input wire logic [REG_W-1:0] ins_dst,
	input wire logic [ADDR_W-1:0] ins_addr,
	input wire logic [SIZE_W-1:0] ins_size,
	input wire logic [TGT_W-1:0] ins_target,
	input wire logic ld_fault,
	input wire logic [FP_W-1:0] fp_src_data,
	input wire logic [DATA_W-1:0] gr_src_data,
	input wire logic [DATA_W-1:0] mem_rd_data,
	input wire logic ucr_wr,
	input wire logic [UCR_W-1:0] ucr_wr_data,
	output logic consume_fault,
	output logic recover_br,
	output logic [TGT_W-1:0] recover_tgt,
	output logic test_result,
	output logic gr_wr_en,
	output logic [REG_W-1:0] gr_wr_idx,
	output logic gr_wr_token,
	output logic [DATA_W-1:0] gr_wr_data,
	output logic fp_tok_wr,
	output logic [FP_W-1:0] fp_wr_data,
	output logic mem_wr_en,
	output logic [DATA_W-1:0] mem_wr_data,
	output logic [FP_W-1:0] fp_mem_wr_data,
	output logic [UCR_W-1:0] ucr_q
);
	dft_advanced_load_address_table_if advanced_load_address_table ();

	dft_advanced_load_address_table #(.NUM(ADVANCED_LOAD_ADDRESS_TABLE_NUM)) u_advanced_load_address_table (
		.clk(clk),
		.srst(srst),
		.t(advanced_load_address_table)
	);

	// one token bit per general register
	// token state private to each register
	logic [GR_NUM-1:0] tok_ff, nxt_tok;
	logic [UCR_W-1:0] ucr_ff, nxt_ucr;
	logic flt_ff, nxt_flt, br_ff, nxt_br, tst_ff, nxt_tst;
	logic gwe_ff, nxt_gwe, gtk_ff, nxt_gtk, fte_ff, nxt_fte, mwe_ff, nxt_mwe;
	logic [REG_W-1:0] gix_ff, nxt_gix;
	logic [TGT_W-1:0] tgt_ff, nxt_tgt;
	logic [DATA_W-1:0] gdt_ff, nxt_gdt, mdt_ff, nxt_mdt;
	logic [FP_W-1:0] fdt_ff, nxt_fdt;
	logic [FP_W-1:0] fmd_ff, nxt_fmd;
	logic gr_tok, fp_tok, src_tok, adr_tok;
	logic [SEL_HI-SEL_LO:0] sel;

	// set bit means deferred fault, not data
	assign gr_tok = (ins_src1_use && tok_ff[ins_src1]) ||
		(ins_src2_use && tok_ff[ins_src2]);
	// fp deferral carried by token encoding
	assign fp_tok = ins_fp && fp_src_data == FP_TOKEN_VAL;
	assign src_tok = gr_tok || fp_tok;
	assign adr_tok = ins_src1_use && tok_ff[ins_src1];
	// bits 8 to 3 pick the collection bit
	assign sel = ins_addr[SEL_HI:SEL_LO];

	always_comb begin
		nxt_tok = tok_ff;
		nxt_ucr = ucr_wr ? ucr_wr_data : ucr_ff;
		nxt_flt = 1'b0;
		nxt_br = 1'b0;
		nxt_tgt = tgt_ff;
		nxt_tst = tst_ff;
		nxt_gwe = 1'b0;
		nxt_gix = ins_dst;
		nxt_gtk = 1'b0;
		nxt_gdt = gdt_ff;
		nxt_fte = 1'b0;
		nxt_fdt = fdt_ff;
		nxt_mwe = 1'b0;
		nxt_mdt = mdt_ff;
		nxt_fmd = fmd_ff;
		advanced_load_address_table.alloc = 1'b0;
		advanced_load_address_table.drop = 1'b0;
		advanced_load_address_table.alloc_reg = ins_dst;
		advanced_load_address_table.alloc_addr = ins_addr;
		advanced_load_address_table.alloc_size = ins_size;
		advanced_load_address_table.alloc_fp = ins_fp;
		advanced_load_address_table.store = 1'b0;
		advanced_load_address_table.st_addr = ins_addr;
		advanced_load_address_table.st_size = ins_size;
		advanced_load_address_table.chk_reg = ins_src1;
		advanced_load_address_table.chk_fp = ins_fp;
		if (ins_valid) begin
			case (ins_op)
				OP_ALU: begin
					if (ins_spec) begin
						nxt_gtk = src_tok;
						nxt_gwe = ins_dst_use && !ins_fp;
						nxt_fte = ins_dst_use && ins_fp && src_tok;
					end else begin
						nxt_flt = src_tok;
						nxt_gwe = ins_dst_use && !ins_fp && !src_tok;
					end
				end
				OP_LD, OP_LD_A: begin
					nxt_flt = adr_tok;
					nxt_gwe = !adr_tok && !ins_fp;
					nxt_gdt = mem_rd_data;
					advanced_load_address_table.alloc = ins_op == OP_LD_A && !adr_tok;
				end
				OP_LD_S, OP_SPECULATIVE_ADVANCED_LOAD: begin
					nxt_gtk = src_tok || ld_fault;
					nxt_gwe = !ins_fp;
					nxt_fte = ins_fp && nxt_gtk;
					nxt_gdt = mem_rd_data;
					advanced_load_address_table.alloc = ins_op == OP_SPECULATIVE_ADVANCED_LOAD && !nxt_gtk;
					advanced_load_address_table.drop = ins_op == OP_SPECULATIVE_ADVANCED_LOAD && nxt_gtk;
				end
				OP_ST: begin
					nxt_flt = src_tok;
					nxt_mwe = !src_tok;
					nxt_mdt = gr_src_data;
					advanced_load_address_table.store = !src_tok;
				end
				OP_SPILL: begin
					nxt_flt = adr_tok;
					nxt_mwe = !adr_tok;
					nxt_mdt = gr_src_data;
					if (!adr_tok)
						nxt_ucr[sel] = tok_ff[ins_src2];
					advanced_load_address_table.store = !adr_tok;
					advanced_load_address_table.st_size = SPILL_SIZE;
				end
				OP_FILL: begin
					nxt_flt = adr_tok;
					nxt_gwe = !adr_tok;
					nxt_gtk = ucr_ff[sel];
					nxt_gdt = mem_rd_data;
				end
				OP_CHK_S: begin
					nxt_br = src_tok;
					if (src_tok)
						nxt_tgt = ins_target;
				end
				OP_CHK_A: begin
					nxt_br = !advanced_load_address_table.chk_hit;
					if (!advanced_load_address_table.chk_hit)
						nxt_tgt = ins_target;
				end
				OP_TNAT: nxt_tst = tok_ff[ins_src1];
				OP_FCLASS: nxt_tst = fp_src_data == FP_TOKEN_VAL;
				OP_FSPILL: begin
					nxt_flt = adr_tok;
					nxt_mwe = !adr_tok;
					nxt_fmd = fp_src_data;
					advanced_load_address_table.store = !adr_tok;
				end
				OP_FFILL: nxt_flt = adr_tok;
				default: nxt_flt = 1'b0;
			endcase
		end
		if (nxt_gwe)
			nxt_tok[ins_dst] = nxt_gtk;
		if (nxt_fte)
			nxt_fdt = FP_TOKEN_VAL;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tok_ff <= '0;
			ucr_ff <= '0;
			flt_ff <= 1'b0;
			br_ff <= 1'b0;
			tgt_ff <= '0;
			tst_ff <= 1'b0;
			gwe_ff <= 1'b0;
			gix_ff <= '0;
			gtk_ff <= 1'b0;
			gdt_ff <= '0;
			fte_ff <= 1'b0;
			fdt_ff <= '0;
			mwe_ff <= 1'b0;
			mdt_ff <= '0;
			fmd_ff <= '0;
		end else begin
			tok_ff <= nxt_tok;
			ucr_ff <= nxt_ucr;
			flt_ff <= nxt_flt;
			br_ff <= nxt_br;
			tgt_ff <= nxt_tgt;
			tst_ff <= nxt_tst;
			gwe_ff <= nxt_gwe;
			gix_ff <= nxt_gix;
			gtk_ff <= nxt_gtk;
			gdt_ff <= nxt_gdt;
			fte_ff <= nxt_fte;
			fdt_ff <= nxt_fdt;
			mwe_ff <= nxt_mwe;
			mdt_ff <= nxt_mdt;
			fmd_ff <= nxt_fmd;
		end
	end

	assign consume_fault = flt_ff;
	assign recover_br = br_ff;
	assign recover_tgt = tgt_ff;
	assign test_result = tst_ff;
	assign gr_wr_en = gwe_ff;
	assign gr_wr_idx = gix_ff;
	assign gr_wr_token = gtk_ff;
	assign gr_wr_data = gdt_ff;
	assign fp_tok_wr = fte_ff;
	assign fp_wr_data = fdt_ff;
	assign mem_wr_en = mwe_ff;
	assign mem_wr_data = mdt_ff;
	assign fp_mem_wr_data = fmd_ff;
	assign ucr_q = ucr_ff;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	property p_ld_defer;
		ins_valid && ins_op == OP_LD_S && ld_fault && !ins_fp |=>
			tok_ff[$past(ins_dst)] && gr_wr_en && gr_wr_token;
	endproperty
	a_ld_defer: assert property (p_ld_defer)
		else $error("deferred load fault did not set token");

	property p_prop;
		ins_valid && ins_op == OP_ALU && ins_spec && gr_tok && ins_dst_use &&
			!ins_fp |=> tok_ff[$past(ins_dst)];
	endproperty
	a_prop: assert property (p_prop)
		else $error("token not carried to destination");

	property p_consume;
		ins_valid && ins_op == OP_ALU && !ins_spec && src_tok |=>
			consume_fault && !gr_wr_en;
	endproperty
	a_consume: assert property (p_consume)
		else $error("tokened read did not fault");

	property p_fp_tok;
		ins_valid && ins_op == OP_ALU && ins_spec && fp_tok && ins_dst_use |=>
			fp_tok_wr && fp_wr_data == FP_TOKEN_VAL;
	endproperty
	a_fp_tok: assert property (p_fp_tok)
		else $error("fp token value not written");

	property p_chk_br;
		ins_valid && ins_op == OP_CHK_S && src_tok |=>
			recover_br && recover_tgt == $past(ins_target) && !consume_fault;
	endproperty
	a_chk_br: assert property (p_chk_br)
		else $error("check did not branch to recovery");

	property p_chk_fall;
		ins_valid && ins_op == OP_CHK_S && !src_tok |=>
			!recover_br && !consume_fault && $stable(tok_ff);
	endproperty
	a_chk_fall: assert property (p_chk_fall)
		else $error("clear check had a side effect");

	property p_tnat;
		ins_valid && ins_op == OP_TNAT |=>
			test_result == $past(tok_ff[ins_src1]);
	endproperty
	a_tnat: assert property (p_tnat)
		else $error("token test wrong");

	property p_spill;
		ins_valid && ins_op == OP_SPILL && !adr_tok && !ucr_wr |=>
			ucr_q[$past(sel)] == $past(tok_ff[ins_src2]) && mem_wr_en &&
			mem_wr_data == $past(gr_src_data);
	endproperty
	a_spill: assert property (p_spill)
		else $error("spill did not save token");

	property p_fill;
		ins_valid && ins_op == OP_FILL && !adr_tok |=>
			tok_ff[$past(ins_dst)] == $past(ucr_ff[sel]);
	endproperty
	a_fill: assert property (p_fill)
		else $error("fill did not restore token");

	property p_sa_noalloc;
		ins_valid && ins_op == OP_SPECULATIVE_ADVANCED_LOAD && (ld_fault || src_tok) ##1
			(advanced_load_address_table.chk_reg == $past(ins_dst) && advanced_load_address_table.chk_fp == $past(ins_fp))
			|-> !advanced_load_address_table.chk_hit;
	endproperty
	a_sa_noalloc: assert property (p_sa_noalloc)
		else $error("tokened load allocated an entry");

	property p_fspill;
		ins_valid && ins_op == OP_FSPILL && !adr_tok |=>
			!consume_fault && fp_mem_wr_data == $past(fp_src_data);
	endproperty
	a_fspill: assert property (p_fspill)
		else $error("fp spill faulted or altered data");
endmodule

/* File: dv/tb_top.sv */
// self-checking bench for the deferred fault token unit
// assumes dft_core answers on the taking edge itself, outputs sampled 1 ns after it
`timescale 1ns/1ps
module tb_top;
	import dft_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ins_valid = 1'b0, ins_spec = 1'b0, ins_fp = 1'b0;
	dft_op_t ins_op = OP_ALU;
	logic ins_src1_use = 1'b0, ins_src2_use = 1'b0, ins_dst_use = 1'b0;
	logic [REG_W-1:0] ins_src1 = '0, ins_src2 = '0, ins_dst = '0;
	logic [ADDR_W-1:0] ins_addr = '0;
	logic [SIZE_W-1:0] ins_size = SPILL_SIZE;
	logic [TGT_W-1:0] ins_target = '0;
	logic ld_fault = 1'b0, ucr_wr = 1'b0;
	logic [FP_W-1:0] fp_src_data = '0;
	logic [DATA_W-1:0] gr_src_data = '0, mem_rd_data = '0;
	logic [UCR_W-1:0] ucr_wr_data = '0;
	logic consume_fault, recover_br, test_result, gr_wr_en, gr_wr_token;
	logic fp_tok_wr, mem_wr_en;
	logic [TGT_W-1:0] recover_tgt;
	logic [REG_W-1:0] gr_wr_idx;
	logic [DATA_W-1:0] gr_wr_data, mem_wr_data;
	logic [FP_W-1:0] fp_wr_data, fp_mem_wr_data;
	logic [UCR_W-1:0] ucr_q, ucr_exp;
	logic [31:0] seed = 32'hd785;
	int error_cnt = 0;
	int n_checks = 0;
	logic [ADDR_W-1:0] a;
	logic tok;

	always #2.5 clk = ~clk;

	dft_core dft_core_inst (.clk(clk), .srst(srst), .ins_valid(ins_valid),
		.ins_op(ins_op), .ins_spec(ins_spec), .ins_fp(ins_fp),
		.ins_src1_use(ins_src1_use), .ins_src2_use(ins_src2_use),
		.ins_src1(ins_src1), .ins_src2(ins_src2), .ins_dst_use(ins_dst_use),
		.ins_dst(ins_dst), .ins_addr(ins_addr), .ins_size(ins_size),
		.ins_target(ins_target), .ld_fault(ld_fault),
		.fp_src_data(fp_src_data), .gr_src_data(gr_src_data),
		.mem_rd_data(mem_rd_data), .ucr_wr(ucr_wr), .ucr_wr_data(ucr_wr_data),
		.consume_fault(consume_fault), .recover_br(recover_br),
		.recover_tgt(recover_tgt), .test_result(test_result),
		.gr_wr_en(gr_wr_en), .gr_wr_idx(gr_wr_idx), .gr_wr_token(gr_wr_token),
		.gr_wr_data(gr_wr_data), .fp_tok_wr(fp_tok_wr),
		.fp_wr_data(fp_wr_data), .mem_wr_en(mem_wr_en),
		.mem_wr_data(mem_wr_data), .fp_mem_wr_data(fp_mem_wr_data),
		.ucr_q(ucr_q));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// collection register after a spill touches only the selected bit
	function automatic logic [UCR_W-1:0] spill_ucr(input logic [UCR_W-1:0] u,
		input logic [ADDR_W-1:0] ad, input logic t);
		u[ad[SEL_HI:SEL_LO]] = t;
		return u;
	endfunction

	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// one instruction, taken at the next edge, outputs checked after it
	task automatic issue(input dft_op_t op, input logic spec,
		input logic [REG_W-1:0] s1, input logic [REG_W-1:0] s2,
		input logic [REG_W-1:0] d, input logic [ADDR_W-1:0] ad,
		input logic flt);
		seed = lfsr(seed);
		ins_valid = 1'b1;
		ins_op = op;
		ins_spec = spec;
		ins_src1 = s1;
		ins_src2 = s2;
		ins_dst = d;
		ins_src1_use = 1'b1;
		ins_src2_use = 1'b1;
		ins_dst_use = 1'b1;
		ins_addr = ad;
		ld_fault = flt;
		ins_target = {seed, ~seed};
		gr_src_data = {~seed, seed};
		mem_rd_data = {seed, seed};
		@(posedge clk);
		#1;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		repeat (16) @(posedge clk);
		#1;
		srst = 1'b0;
		// reset leaves outputs and collection clear
		chk({consume_fault, recover_br, gr_wr_en, mem_wr_en}, 4'h0);
		chk(ucr_q, 64'h0);
		// deferred fault sets destination token
		issue(OP_LD_S, 1'b1, 7'h01, 7'h00, 7'h05, 64'h100, 1'b1);
		chk({gr_wr_en, gr_wr_idx, gr_wr_token}, {1'b1, 7'h05, 1'b1});
		// check precedes use
		// check on tokened register branches
		issue(OP_CHK_S, 1'b0, 7'h05, 7'h00, 7'h00, 64'h0, 1'b0);
		chk({recover_br, recover_tgt}, {1'b1, ins_target});
		// check on clean register falls through
		issue(OP_CHK_S, 1'b0, 7'h02, 7'h00, 7'h00, 64'h0, 1'b0);
		chk({recover_br, consume_fault, gr_wr_en}, 3'h0);
		// token flows through speculative op
		issue(OP_ALU, 1'b1, 7'h00, 7'h05, 7'h06, 64'h0, 1'b0);
		chk({gr_wr_en, gr_wr_idx, gr_wr_token}, {1'b1, 7'h06, 1'b1});
		// token test reports the bit
		issue(OP_TNAT, 1'b0, 7'h06, 7'h00, 7'h00, 64'h0, 1'b0);
		chk(test_result, 1'b1);
		issue(OP_TNAT, 1'b0, 7'h07, 7'h00, 7'h00, 64'h0, 1'b0);
		chk(test_result, 1'b0);
		// non-speculative consumer faults, no writeback
		issue(OP_ALU, 1'b0, 7'h05, 7'h00, 7'h08, 64'h0, 1'b0);
		chk({consume_fault, gr_wr_en}, 2'h2);
		// load through tokened address faults
		issue(OP_LD, 1'b0, 7'h05, 7'h00, 7'h09, 64'h0, 1'b0);
		chk({consume_fault, gr_wr_en}, 2'h2);
		// a clean speculative load leaves other tokens alone
		issue(OP_LD_S, 1'b1, 7'h01, 7'h00, 7'h0c, 64'h200, 1'b0);
		chk({gr_wr_en, gr_wr_token, gr_wr_data}, {2'h2, mem_rd_data});
		issue(OP_TNAT, 1'b0, 7'h05, 7'h00, 7'h00, 64'h0, 1'b0);
		chk(test_result, 1'b1);
		// fp deferral writes the token value
		ins_fp = 1'b1;
		issue(OP_LD_S, 1'b1, 7'h01, 7'h00, 7'h03, 64'h300, 1'b1);
		chk({fp_tok_wr, fp_wr_data}, {1'b1, FP_TOKEN_VAL});
		fp_src_data = FP_TOKEN_VAL;
		issue(OP_FCLASS, 1'b0, 7'h00, 7'h00, 7'h00, 64'h0, 1'b0);
		chk(test_result, 1'b1);
		// speculative fp op on token value passes it on
		issue(OP_ALU, 1'b1, 7'h01, 7'h00, 7'h04, 64'h0, 1'b0);
		chk({fp_tok_wr, gr_wr_en}, 2'h2);
		chk(fp_wr_data, FP_TOKEN_VAL);
		// fp spill of token value raises nothing
		issue(OP_FSPILL, 1'b0, 7'h01, 7'h00, 7'h00, 64'h400, 1'b0);
		chk({consume_fault, mem_wr_en}, 2'h1);
		chk(fp_mem_wr_data, FP_TOKEN_VAL);
		issue(OP_FFILL, 1'b0, 7'h01, 7'h00, 7'h04, 64'h400, 1'b0);
		chk(consume_fault, 1'b0);
		issue(OP_FFILL, 1'b0, 7'h05, 7'h00, 7'h04, 64'h400, 1'b0);
		chk(consume_fault, 1'b1);
		fp_src_data = 82'h0ffff8000000000000000;
		issue(OP_FCLASS, 1'b0, 7'h00, 7'h00, 7'h00, 64'h0, 1'b0);
		chk(test_result, 1'b0);
		ins_fp = 1'b0;
		// advanced load entry, then faulting speculative one drops it
		issue(OP_LD_A, 1'b0, 7'h01, 7'h00, 7'h0a, 64'h700, 1'b0);
		issue(OP_CHK_A, 1'b0, 7'h0a, 7'h00, 7'h00, 64'h0, 1'b0);
		chk(recover_br, 1'b0);
		issue(OP_SPECULATIVE_ADVANCED_LOAD, 1'b1, 7'h01, 7'h00, 7'h0a, 64'h500, 1'b1);
		chk(gr_wr_token, 1'b1);
		issue(OP_CHK_A, 1'b0, 7'h0a, 7'h00, 7'h00, 64'h0, 1'b0);
		chk(recover_br, 1'b1);
		// advanced load then check matches
		issue(OP_LD_A, 1'b0, 7'h01, 7'h00, 7'h0b, 64'h600, 1'b0);
		issue(OP_CHK_A, 1'b0, 7'h0b, 7'h00, 7'h00, 64'h0, 1'b0);
		chk(recover_br, 1'b0);
		// overlapping store removes the entry
		issue(OP_ST, 1'b0, 7'h01, 7'h02, 7'h00, 64'h604, 1'b0);
		chk({mem_wr_en, mem_wr_data}, {1'b1, gr_src_data});
		issue(OP_CHK_A, 1'b0, 7'h0b, 7'h00, 7'h00, 64'h0, 1'b0);
		chk(recover_br, 1'b1);
		seed = lfsr(seed);
		ucr_exp = {seed, ~seed};
		ucr_wr_data = ucr_exp;
		ucr_wr = 1'b1;
		@(posedge clk);
		#1;
		ucr_wr = 1'b0;
		chk(ucr_q, ucr_exp);
		// software write and spill in one cycle, spill bit wins
		ucr_exp = ~ucr_exp;
		ucr_wr_data = ucr_exp;
		ucr_wr = 1'b1;
		issue(OP_SPILL, 1'b0, 7'h01, 7'h06, 7'h00, 64'h1f8, 1'b0);
		ucr_wr = 1'b0;
		ucr_exp = spill_ucr(ucr_exp, 64'h1f8, 1'b1);
		chk(ucr_q, ucr_exp);
		// random spill and fill pairs through the collection register
		for (int i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			a = {seed, seed} & 64'h1f8;
			if (i == 0) begin
				a = 64'h1f8;
			end
			tok = seed[9];
			issue(OP_SPILL, 1'b0, 7'h01, tok ? 7'h06 : 7'h14, 7'h00, a, 1'b0);
			ucr_exp = spill_ucr(ucr_exp, a, tok);
			chk({mem_wr_en, mem_wr_data}, {1'b1, gr_src_data});
			chk(ucr_q, ucr_exp);
			issue(OP_FILL, 1'b0, 7'h01, 7'h00, 7'h28, a, 1'b0);
			chk({gr_wr_en, gr_wr_token}, {1'b1, tok});
			chk(gr_wr_data, mem_rd_data);
		end
		ins_valid = 1'b0;
		@(posedge clk);
		tally_and_finish();
	end
endmodule
